//--- src/aes_adc_seq.sv
// Control and successive-approximation sequencer of the 8-bit converter
//
// Contract
// - Conversion clock divided from system clock by 5-bit config field bits 7..3.
// - Conversion clock equals system clock over field plus one, field 0..31.
// - Gain field bits 1..0 selects one half, one, two or four.
// - Config bit 2 reads zero, writes ignored.
// - Channel field low three bits picks input; upper five bits read zero.
// - Enable bit 7 low holds shutdown; high accepts conversion starts.
// - Normal track mode tracks continuously except during conversion.
// - Completion flag set on completion; only software writing zero clears it.
// - Busy reads one during conversion; its falling edge sets completion flag.
// - Busy falling edge also raises interrupt request when enabled.
// - Busy write zero does nothing; write one starts only in mode 000.
// - Mode 000 software, 001 timer three, 011 timer two overflow.
// - Mode 010 normal tracking converts on each external start rising edge.
// - Mode 1xx starts when software writes one to companion busy bit.
// - Low-power mode non-pin triggers track three conversion clocks first.
// - Low-power mode 010 tracks while pin low, converts on rising edge.
// - Control bit 0 reads zero, writes ignored.
// - Result is 8-bit straight binary; half reference 0x80, maximum 0xFF.
`timescale 1ns/10ps
`default_nettype none
`include "aes_adc_regs.svh"

module aes_adc_seq #(
    parameter int SAR_CLOCKS = `AES_SAR_CLOCKS
) (
    input  wire logic       clk,             // System clock, 50 MHz
    input  wire logic       reset,           // Synchronous reset, high
    input  wire logic [7:0] sfr_addr,        // Register address
    input  wire logic [7:0] sfr_wdata,       // Write data
    input  wire logic       sfr_wr,          // Write strobe
    output logic      [7:0] sfr_rdata,       // Read data, registered
    input  wire logic       timer3_overflow, // Timer three overflow pulse
    input  wire logic       timer2_overflow, // Timer two overflow pulse
    input  wire logic       companion_busy,  // Companion busy-bit write-one pulse
    input  wire logic       ext_convert_start, // External start pin
    input  wire logic       comparator_in,   // Comparator: input above DAC
    input  wire logic       irq_enable,      // Interrupt enable from core
    output logic            irq_request,     // Interrupt request pulse
    output logic            track_enable,    // Track-and-hold tracking
    output logic            analog_power,    // Converter powered
    output logic      [7:0] sar_dac,         // Trial code to DAC
    output logic      [2:0] channel_select,  // Mux channel
    output logic      [1:0] gain_select,     // Amplifier gain code
    output logic            conversion_clock // Conversion clock tick
);

    typedef struct packed {
        logic                converter_enable;
        logic                track_mode;
        logic                completion_flag;
        logic [2:0]          start_mode;
        logic [4:0]          conv_clock_divider;
        logic [1:0]          gain_select;
        logic [2:0]          channel_select;
        logic [7:0]          result;
        aes_pkg::aes_state_t state;
        logic [1:0]          track_cnt;
        logic [7:0]          sar;
        logic [3:0]          bit_idx;
        logic                ext_prev;
        logic [7:0]          rdata;
        logic                irq;
        logic                track;
        logic                tick;
        logic [7:0]          dac;
    } aes_seq_state_t;

    aes_seq_state_t st_r;
    aes_seq_state_t st_nxt;

    logic div_tick;
    logic ext_sync;
    logic div_restart;

    // One-hot trial bit for a given position; positions past the top bit add none
    function automatic logic [7:0] bit_mask(input logic [3:0] idx);
        if (idx > 4'h7)
        begin
            bit_mask = 8'h00;
        end
        else
        begin
            bit_mask = 8'h01 << idx[2:0];
        end
    endfunction

    // Conversion clock: restarts on idle so each phase starts on a full period
    assign div_restart = (st_r.state == aes_pkg::AES_ST_IDLE);

    // conversion clock divider, period of field plus one
    aes_clk_div #(
        .WIDTH (5)
    ) u_div (
        .clk     (clk),
        .reset   (reset),
        .restart (div_restart),
        .ratio   (st_r.conv_clock_divider),
        .tick    (div_tick)
    );

    // External start pin synchroniser
    aes_sync u_sync (
        .clk   (clk),
        .reset (reset),
        .d     (ext_convert_start),
        .q     (ext_sync)
    );

    // Register writes, triggers and sequencer
    always_comb
    begin
        logic       sw_start;
        logic       trig;
        logic       ext_rise;
        logic       mode_ext;
        logic       done;
        logic [7:0] trial;
        sw_start = 1'b0;
        trig     = 1'b0;
        ext_rise = 1'b0;
        mode_ext = 1'b0;
        done     = 1'b0;
        trial    = 8'h00;
        st_nxt = st_r;
        st_nxt.irq = 1'b0;
        st_nxt.tick = div_tick;
        st_nxt.ext_prev = ext_sync;
        ext_rise = ext_sync && !st_r.ext_prev;
        mode_ext = (st_r.start_mode == aes_pkg::AES_MODE_EXT);

        // Register writes
        if (sfr_wr && sfr_addr == `AES_CTRL_ADDR)
        begin
            st_nxt.converter_enable = sfr_wdata[`AES_CTRL_EN_BIT];
            st_nxt.track_mode = sfr_wdata[`AES_CTRL_TM_BIT];
            // software clears flag only by zero
            if (!sfr_wdata[`AES_CTRL_FLAG_BIT])
            begin
                st_nxt.completion_flag = 1'b0;
            end
            st_nxt.start_mode = sfr_wdata[`AES_CTRL_MODE_HI:`AES_CTRL_MODE_LO];
            // busy write one starts only in mode 000
            sw_start = sfr_wdata[`AES_CTRL_BUSY_BIT]
                && st_r.start_mode == aes_pkg::AES_MODE_SW;
        end
        else if (sfr_wr && sfr_addr == `AES_CFG_ADDR)
        begin
            st_nxt.conv_clock_divider = sfr_wdata[`AES_CFG_DIV_HI:`AES_CFG_DIV_LO];
            st_nxt.gain_select = sfr_wdata[`AES_CFG_GAIN_HI:`AES_CFG_GAIN_LO];
        end
        else if (sfr_wr && sfr_addr == `AES_MUX_ADDR)
        begin
            st_nxt.channel_select = sfr_wdata[`AES_MUX_CH_HI:0];
        end

        if (st_r.start_mode[2])
        begin
            trig = companion_busy;
        end
        else if (st_r.start_mode == aes_pkg::AES_MODE_TMR3)
        begin
            trig = timer3_overflow;
        end
        else if (st_r.start_mode == aes_pkg::AES_MODE_TMR2)
        begin
            trig = timer2_overflow;
        end
        else if (mode_ext)
        begin
            trig = ext_rise;
        end
        else
        begin
            trig = sw_start;
        end

        // Sequencer
        case (st_r.state)
            aes_pkg::AES_ST_IDLE:
            begin
                st_nxt.track = st_r.converter_enable
                    && (!st_r.track_mode || (mode_ext && !ext_sync));
                if (st_r.converter_enable && trig)
                begin
                    st_nxt.sar = 8'h00;
                    st_nxt.bit_idx = 4'(SAR_CLOCKS - 1);
                    st_nxt.track_cnt = 2'h0;
                    if (st_r.track_mode && !mode_ext)
                    begin
                        st_nxt.state = aes_pkg::AES_ST_TRACK;
                        st_nxt.track = 1'b1;
                    end
                    else
                    begin
                        // pin mode converts on the edge
                        st_nxt.state = aes_pkg::AES_ST_CONV;
                        st_nxt.track = 1'b0;
                    end
                end
            end
            aes_pkg::AES_ST_TRACK:
            begin
                if (div_tick)
                begin
                    if (st_r.track_cnt == `AES_TRACK_CLOCKS - 2'h1)
                    begin
                        st_nxt.state = aes_pkg::AES_ST_CONV;
                        st_nxt.track = 1'b0;
                    end
                    else
                    begin
                        st_nxt.track_cnt = st_r.track_cnt + 2'h1;
                    end
                end
            end
            aes_pkg::AES_ST_CONV:
            begin
                st_nxt.track = 1'b0;
                // one comparator sample per conversion clock, MSB first
                if (div_tick)
                begin
                    trial = st_r.sar | bit_mask(st_r.bit_idx);
                    if (comparator_in)
                    begin
                        st_nxt.sar = trial;
                    end
                    if (st_r.bit_idx == 4'h0)
                    begin
                        done = 1'b1;
                    end
                    else
                    begin
                        st_nxt.bit_idx = st_r.bit_idx - 4'h1;
                    end
                end
            end
            default:
            begin
                st_nxt.state = aes_pkg::AES_ST_IDLE;
            end
        endcase

        // fixed length; excess clocks beyond eight bits come first, before the MSB trial
        if (done)
        begin
            st_nxt.result = comparator_in ? trial : st_r.sar;
            st_nxt.state = aes_pkg::AES_ST_IDLE;
            // set wins over a concurrent clear
            st_nxt.completion_flag = 1'b1;
            st_nxt.irq = irq_enable;
        end

        // shutdown aborts any conversion; new enable so tracking drops with power
        if (!st_nxt.converter_enable)
        begin
            st_nxt.state = aes_pkg::AES_ST_IDLE;
            st_nxt.track = 1'b0;
        end

        // Trial code to the DAC: current bit added while converting
        if (st_nxt.state == aes_pkg::AES_ST_CONV)
        begin
            st_nxt.dac = st_nxt.sar | bit_mask(st_nxt.bit_idx);
        end
        else
        begin
            st_nxt.dac = st_nxt.sar;
        end

        // Registered read data
        if (sfr_addr == `AES_CTRL_ADDR)
        begin
            // busy bit reflects state; bit 0 zero
            st_nxt.rdata = {st_r.converter_enable, st_r.track_mode, st_r.completion_flag,
                            st_r.state != aes_pkg::AES_ST_IDLE, st_r.start_mode, 1'b0};
        end
        else if (sfr_addr == `AES_CFG_ADDR)
        begin
            st_nxt.rdata = {st_r.conv_clock_divider, 1'b0, st_r.gain_select};
        end
        else if (sfr_addr == `AES_MUX_ADDR)
        begin
            st_nxt.rdata = {5'h00, st_r.channel_select};
        end
        else if (sfr_addr == `AES_RESULT_ADDR)
        begin
            st_nxt.rdata = st_r.result;
        end
        else
        begin
            st_nxt.rdata = 8'h00;
        end
    end

    // State register with documented reset values
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_r <= '0;
            st_r.conv_clock_divider <= 5'h1F;
            st_r.state <= aes_pkg::AES_ST_IDLE;
            // Pin idles high; avoids a false edge after reset
            st_r.ext_prev <= 1'b1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // Outputs straight from flip-flops
    assign sfr_rdata        = st_r.rdata;
    assign irq_request      = st_r.irq;
    assign track_enable     = st_r.track;
    assign analog_power     = st_r.converter_enable;
    assign sar_dac          = st_r.dac;
    assign channel_select   = st_r.channel_select;
    assign gain_select      = st_r.gain_select;
    assign conversion_clock = st_r.tick;

endmodule
`default_nettype wire

//--- include/aes_adc_regs.svh
// Register offsets, field positions, reset values and timing counts of the 8-bit converter sequencer
`ifndef AES_ADC_REGS_SVH
`define AES_ADC_REGS_SVH

`define AES_CTRL_ADDR      8'hAA
`define AES_CFG_ADDR       8'hAB
`define AES_MUX_ADDR       8'hAC
`define AES_RESULT_ADDR    8'hBE

`define AES_CTRL_RESET     8'h00
`define AES_CFG_RESET      8'hF8
`define AES_MUX_RESET      8'h00

`define AES_CTRL_EN_BIT    7
`define AES_CTRL_TM_BIT    6
`define AES_CTRL_FLAG_BIT  5
`define AES_CTRL_BUSY_BIT  4
`define AES_CTRL_MODE_HI   3
`define AES_CTRL_MODE_LO   1
`define AES_CFG_DIV_HI     7
`define AES_CFG_DIV_LO     3
`define AES_CFG_GAIN_HI    1
`define AES_CFG_GAIN_LO    0
`define AES_MUX_CH_HI      2

`define AES_TRACK_CLOCKS   2'h3
`define AES_SAR_CLOCKS     8

`endif

//--- include/aes_pkg.sv
// Types shared by the converter sequencer modules
package aes_pkg;

    // Start-of-conversion trigger selection
    typedef enum logic [2:0] {
        AES_MODE_SW    = 3'b000,
        AES_MODE_TMR3  = 3'b001,
        AES_MODE_EXT   = 3'b010,
        AES_MODE_TMR2  = 3'b011
    } aes_mode_t;

    // Sequencer states
    typedef enum logic [1:0] {
        AES_ST_IDLE  = 2'b00,
        AES_ST_TRACK = 2'b01,
        AES_ST_CONV  = 2'b10
    } aes_state_t;

    // Gain codes
    typedef enum logic [1:0] {
        AES_GAIN_HALF = 2'b00,
        AES_GAIN_ONE  = 2'b01,
        AES_GAIN_TWO  = 2'b10,
        AES_GAIN_FOUR = 2'b11
    } aes_gain_t;

endpackage

//--- src/aes_clk_div.sv
// Divider that marks one tick per conversion clock period
`timescale 1ns/10ps
`default_nettype none

module aes_clk_div #(
    parameter int WIDTH = 5
) (
    input  wire logic             clk,     // System clock
    input  wire logic             reset,   // Synchronous reset, high
    input  wire logic             restart, // Restart period at zero
    input  wire logic [WIDTH-1:0] ratio,   // Period minus one
    output logic                  tick     // One-cycle pulse per period
);

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
        logic             tick;
    } aes_div_state_t;

    aes_div_state_t st_r;
    aes_div_state_t st_nxt;

    // Count up to ratio, then wrap and tick
    always_comb
    begin
        st_nxt = st_r;
        st_nxt.tick = 1'b0;
        if (restart)
        begin
            st_nxt.cnt = '0;
        end
        else if (st_r.cnt >= ratio)
        begin
            st_nxt.cnt = '0;
            st_nxt.tick = 1'b1;
        end
        else
        begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            st_r <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign tick = st_r.tick;

endmodule
`default_nettype wire

//--- src/aes_sync.sv
// Two-stage synchroniser for a pin input
`timescale 1ns/10ps
`default_nettype none

module aes_sync (
    input  wire logic clk,   // System clock
    input  wire logic reset, // Synchronous reset, high
    input  wire logic d,     // Asynchronous input
    output logic      q      // Synchronised level
);

    typedef struct packed {
        logic s1;
        logic s2;
    } aes_sync_state_t;

    aes_sync_state_t st_r;
    aes_sync_state_t st_nxt;

    // Shift through two stages
    always_comb
    begin
        st_nxt.s1 = d;
        st_nxt.s2 = st_r.s1;
    end

    // State register
    always_ff @(posedge clk)
    begin
        // Reset to the idle-high pin level so no false edge follows reset
        if (reset)
        begin
            st_r <= '1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign q = st_r.s2;

endmodule
`default_nettype wire

//--- verification/aes_adc_chk.sv
// Port checks of the converter sequencer
`timescale 1ns/10ps
`default_nettype none
`include "aes_adc_regs.svh"

module aes_adc_chk (
    input wire logic       clk,            // System clock
    input wire logic       reset,          // Synchronous reset
    input wire logic [7:0] sfr_addr,       // Register address
    input wire logic [7:0] sfr_wdata,      // Write data
    input wire logic       sfr_wr,         // Write strobe
    input wire logic [7:0] sfr_rdata,      // Read data
    input wire logic       irq_request,    // Interrupt pulse
    input wire logic       track_enable,   // Tracking
    input wire logic       analog_power,   // Powered
    input wire logic [2:0] channel_select, // Channel
    input wire logic [1:0] gain_select,    // Gain
    input wire logic       irq_enable      // Interrupt enable
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Write to one register
    sequence s_wr(a);
        sfr_wr && sfr_addr == a;
    endsequence
    sequence s_shutdown;
        sfr_wr && sfr_addr == `AES_CTRL_ADDR && !sfr_wdata[7] ##1 !sfr_wr;
    endsequence

    // Fields follow their writes
    a_power_follows_write: assert property (s_wr(`AES_CTRL_ADDR) |=> analog_power == $past(sfr_wdata[7]))
        else $error("power differs from written enable");
    a_gain_follows_write: assert property (s_wr(`AES_CFG_ADDR) |=> gain_select == $past(sfr_wdata[1:0]))
        else $error("gain differs from written field");
    a_chan_follows_write: assert property (s_wr(`AES_MUX_ADDR) |=> channel_select == $past(sfr_wdata[2:0]))
        else $error("channel differs from written field");
    // Unused bits read zero
    a_cfg_gap_zero: assert property ($past(sfr_addr) == `AES_CFG_ADDR |-> !sfr_rdata[2])
        else $error("config bit 2 reads one");
    a_mux_upper_zero: assert property ($past(sfr_addr) == `AES_MUX_ADDR |-> sfr_rdata[7:3] == 5'h0)
        else $error("mux upper bits read nonzero");
    a_ctrl_low_zero: assert property ($past(sfr_addr) == `AES_CTRL_ADDR |-> !sfr_rdata[0])
        else $error("control bit 0 reads one");
    // Interrupt and shutdown
    a_irq_one_cycle: assert property (irq_request |=> !irq_request)
        else $error("interrupt pulse longer than one cycle");
    a_irq_needs_enable: assert property (irq_request |-> $past(irq_enable))
        else $error("interrupt raised while disabled");
    a_shutdown_no_track: assert property (s_shutdown |=> !track_enable && !analog_power)
        else $error("tracking while shut down");
endmodule

bind aes_adc_seq aes_adc_chk u_chk (
    .clk            (clk),
    .reset          (reset),
    .sfr_addr       (sfr_addr),
    .sfr_wdata      (sfr_wdata),
    .sfr_wr         (sfr_wr),
    .sfr_rdata      (sfr_rdata),
    .irq_request    (irq_request),
    .track_enable   (track_enable),
    .analog_power   (analog_power),
    .channel_select (channel_select),
    .gain_select    (gain_select),
    .irq_enable     (irq_enable)
);
`default_nettype wire

//--- verification/aes_front_model.sv
// Track-and-hold and comparator model of the analog side
`timescale 1ns/10ps
`default_nettype none

module aes_front_model (
    input  wire logic       clk,           // System clock
    input  wire logic       analog_power,  // Powered
    input  wire logic       track_enable,  // Tracking
    input  wire logic [7:0] sar_dac,       // Trial code
    input  wire logic [7:0] level,         // Input level as code
    output logic            comparator_in  // Input at or above trial
);
    logic [7:0] held_r;
    logic       toggle_r;
    always @(posedge clk)
    begin
        if (track_enable)
            held_r <= level;
        toggle_r <= ~toggle_r;
    end
    assign comparator_in = analog_power ? (held_r >= sar_dac) : toggle_r;
    initial toggle_r = 1'b0;
endmodule
`default_nettype wire

//--- verification/aes_adc_seq_tb.sv
// Register-level testbench of the converter sequencer
`timescale 1ns/10ps
`default_nettype none
`include "aes_adc_regs.svh"

module aes_adc_seq_tb;
    logic       clk = 0, reset = 1, sfr_wr = 0, t3 = 0, t2 = 0, comp = 0, pin = 1, ie = 1;
    logic [7:0] sfr_addr = 0, sfr_wdata = 0, rdata, level = 0, d, ctl;
    logic       irq, trk, pwr, cmp, cclk;
    logic [7:0] dac;
    logic [2:0] chan;
    logic [1:0] gain;
    int         errors = 0, check_count = 0, ticks = 0, irq_cnt = 0, n, n0, p, i;
    logic [7:0] tgt [5] = '{8'hA5, 8'h80, 8'hFF, 8'h00, 8'h3C};
    logic [2:0] mn [5] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4};
    logic [2:0] ml [5] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd7};
    logic [7:0] dv [3] = '{8'h00, 8'h02, 8'h05};

    aes_adc_seq dut (.clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rdata(rdata), .timer3_overflow(t3), .timer2_overflow(t2), .companion_busy(comp),
        .ext_convert_start(pin), .comparator_in(cmp), .irq_enable(ie), .irq_request(irq), .track_enable(trk),
        .analog_power(pwr), .sar_dac(dac), .channel_select(chan), .gain_select(gain), .conversion_clock(cclk));
    aes_front_model u_front (.clk(clk), .analog_power(pwr), .track_enable(trk), .sar_dac(dac), .level(level),
        .comparator_in(cmp));

    // Clock, tick and interrupt counters
    always #10 clk = ~clk;
    always @(posedge clk)
    begin
        if (cclk === 1'b1)
            ticks <= ticks + 1;
        if (irq === 1'b1)
            irq_cnt <= irq_cnt + 1;
    end

    task check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk); #1;
        sfr_addr = a; sfr_wdata = v; sfr_wr = 1;
        @(posedge clk); #1;
        sfr_wr = 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk); #1;
        sfr_addr = a;
        @(posedge clk); #1;
        d = rdata;
    endtask
    // One trigger of the given start mode
    task trig(input logic [2:0] m);
        if (m == 3'd0)
            wr(`AES_CTRL_ADDR, ctl | 8'h10);
        else if (m == 3'd2)
        begin
            pin = 0;
            repeat (20) @(posedge clk);
            #1;
            check(trk, 1'b1);
            pin = 1;
        end
        else
        begin
            @(posedge clk); #1;
            t3 = (m == 3'd1); t2 = (m == 3'd3); comp = m[2];
            @(posedge clk); #1;
            t3 = 0; t2 = 0; comp = 0;
        end
    endtask
    task conv(input logic tm, input logic [2:0] m, input logic [7:0] v);
        ctl = {1'b1, tm, 2'b00, m, 1'b0};
        wr(`AES_CTRL_ADDR, ctl); // clear flag before the start
        level = v;
        trig(m);
        n = ticks;
        repeat (12) @(posedge clk);
        if (m != 3'd2)
            trig(m);
        rd(`AES_CTRL_ADDR);
        check(d & 8'h10, 8'h10);
        check(trk, 1'b0);
        for (p = 0; p < 3000 && irq !== 1'b1; p++)
            @(posedge clk) #1;
        n = ticks - n;
        check(irq, 1'b1);
        repeat (5) @(posedge clk);
        rd(`AES_CTRL_ADDR);
        check(d & 8'h30, 8'h20);
        rd(`AES_RESULT_ADDR);
        check(d, v);
        wr(`AES_CTRL_ADDR, ctl);
        rd(`AES_CTRL_ADDR);
        check(d & 8'h20, 8'h00);
    endtask
    task end_of_test;
        $display("Errors %0d, checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Watchdog
    initial
    begin
        #400_000;
        errors++;
        end_of_test;
    end
    // Main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        #1 reset = 0;
        rd(`AES_CTRL_ADDR); check(d, 8'h00);
        rd(`AES_CFG_ADDR); check(d, 8'hF8);
        rd(`AES_MUX_ADDR); check(d, 8'h00);
        rd(8'h55); check(d, 8'h00);
        wr(`AES_CFG_ADDR, 8'hFF); rd(`AES_CFG_ADDR); check(d, 8'hFB);
        wr(`AES_MUX_ADDR, 8'hFF); rd(`AES_MUX_ADDR); check(d, 8'h07);
        for (i = 0; i < 8; i++)
        begin
            wr(`AES_MUX_ADDR, i[7:0]); check(chan, i[2:0]);
            wr(`AES_CFG_ADDR, 8'h10 | i[1:0]); check(gain, i[1:0]);
        end
        ie = 0;
        wr(`AES_CTRL_ADDR, 8'h80);
        // Divider only runs while busy, so measure it inside a conversion
        for (i = 0; i < 3; i++)
        begin
            wr(`AES_CFG_ADDR, dv[i] << 3);
            wr(`AES_CTRL_ADDR, 8'h90);
            for (p = 0; p < 100 && cclk !== 1'b1; p++) @(posedge clk) #1;
            p = 0;
            do begin @(posedge clk) #1; p++; end while (cclk !== 1'b1 && p < 100);
            check(p[7:0], dv[i] + 8'h01);
            repeat (60) @(posedge clk);
        end
        rd(`AES_CTRL_ADDR); check(d & 8'h30, 8'h20);
        check(irq_cnt[7:0], 8'h00);
        ie = 1;
        wr(`AES_CFG_ADDR, 8'h10);
        wr(`AES_CTRL_ADDR, 8'h02);
        trig(3'd1);
        repeat (30) @(posedge clk);
        rd(`AES_CTRL_ADDR); check(d, 8'h02);
        check(pwr, 1'b0);
        wr(`AES_CTRL_ADDR, 8'h82);
        wr(`AES_CTRL_ADDR, 8'h93);
        repeat (10) @(posedge clk);
        rd(`AES_CTRL_ADDR); check(d, 8'h82);
        for (i = 0; i < 5; i++)
        begin
            conv(1'b0, mn[i], tgt[i]);
            if (i == 0) n0 = n;
            else if (mn[i] != 3'd2) check(n[7:0], n0[7:0]);
        end
        for (i = 0; i < 5; i++)
        begin
            conv(1'b1, ml[i], tgt[4 - i]);
            if (ml[i] != 3'd2) check(n[7:0], n0[7:0] + 8'h03);
        end
        end_of_test;
    end
endmodule
`default_nettype wire
